// file: design/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// Clock source select field codes.
`define SCP_SEL_WAKEUP      2'h0
`define SCP_SEL_RESERVED    2'h1
`define SCP_SEL_PLL_PRESC   2'h2
`define SCP_SEL_DIRECT      2'h3

// Field and counter widths.
`define SCP_SEL_W           2
`define SCP_FIELD_W         10
`define SCP_FACTOR_W        11
`define SCP_SRC_COUNT       5
`define SCP_STALL_W         12

// Positions of the clock inputs in the synchroniser vector.
`define SCP_IDX_DIRECT      0
`define SCP_IDX_CRYSTAL     1
`define SCP_IDX_INTERNAL    2
`define SCP_IDX_PLL         3
`define SCP_IDX_WAKEUP      4

// Reset values.
`define SCP_SYNC_RST        5'h00
`define SCP_FIELD_RST       10'h000
`define SCP_FACTOR_RST      11'h001
`define SCP_COUNT_RST       11'h000
`define SCP_STALL_RST       12'h000
`define SCP_SEL_RST         2'h0

// Timing: clock period and the silence that marks a stalled source.
`define SCP_CLK_PERIOD_NS   8
`define SCP_STALL_NS        20000
`define SCP_STALL_CYCLES    ((`SCP_STALL_NS) / (`SCP_CLK_PERIOD_NS))

`endif

// file: design/scp_pkg.sv
package scp_pkg;

    typedef enum logic [2:0] {
        SCP_MODE_WAKEUP,
        SCP_MODE_PLL,
        SCP_MODE_PRESCALER,
        SCP_MODE_DIRECT,
        SCP_MODE_RESERVED
    } scp_mode_t;

    // Division factor is the divide field plus one.
    function automatic logic [10:0] scp_factor(input logic [9:0] field);
        scp_factor = {1'b0, field} + 11'h001;
    endfunction

endpackage

// file: design/scp_prescaler.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_prescaler (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    // Control
    input  wire logic                      restart,
    input  wire logic [`SCP_FIELD_W-1:0]   divide_field,
    // Oscillator level, already synchronised
    input  wire logic                      osc_level,
    // Divided clock
    output logic                           div_clk
);

    logic                      osc_prev;
    logic [`SCP_FACTOR_W-1:0]  period_cnt;
    logic                      next_div_clk;
    logic                      next_osc_prev;
    logic [`SCP_FACTOR_W-1:0]  next_period_cnt;
    logic [`SCP_FACTOR_W-1:0]  factor;
    logic [`SCP_FACTOR_W-1:0]  half;
    logic                      osc_rise;

    always_comb begin
        factor          = scp_pkg::scp_factor(divide_field);
        // The high phase lasts ceil(K/2) input periods, so an odd
        // factor puts its extra period in the high phase.
        half            = (factor + 11'h001) >> 1;
        osc_rise        = osc_level && !osc_prev;
        next_osc_prev   = osc_level;
        next_period_cnt = period_cnt;
        next_div_clk    = div_clk;
        if (restart) begin
            next_period_cnt = `SCP_COUNT_RST;
            next_div_clk    = 1'b0;
        end else if (factor == `SCP_FACTOR_RST) begin
            // Factor one follows the input, keeping its duty cycle.
            next_div_clk    = osc_level;
        end else if (osc_rise) begin
            // Counting wraps at the factor, so the count reaches at most 1023 for factor 1024.
            if (period_cnt >= factor - 11'h001) begin
                next_period_cnt = `SCP_COUNT_RST;
            end else begin
                next_period_cnt = period_cnt + 11'h001;
            end
            next_div_clk    = (next_period_cnt < half);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_prev   <= 1'b0;
            period_cnt <= `SCP_COUNT_RST;
            div_clk    <= 1'b0;
        end else if (ce) begin
            osc_prev   <= next_osc_prev;
            period_cnt <= next_period_cnt;
            div_clk    <= next_div_clk;
        end
    end

endmodule

// file: design/scp_clock_source_prescaler.sv
`timescale 1ns/1ps
`include "scp_defs.svh"


module scp_clock_source_prescaler (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    // Configuration from software
    input  wire logic [`SCP_SEL_W-1:0]     clock_source_select,
    input  wire logic                      vco_bypass,
    input  wire logic [`SCP_FIELD_W-1:0]   prescaler_divide_field,
    input  wire logic                      osc_internal_select,
    // Clock sources
    input  wire logic                      direct_clock_input,
    input  wire logic                      crystal_input,
    input  wire logic                      internal_clock_input,
    input  wire logic                      pll_clock_input,
    input  wire logic                      wakeup_clock_input,
    // System clock and status
    output logic                           system_clock,
    output scp_pkg::scp_mode_t             active_mode,
    output logic [`SCP_FACTOR_W-1:0]       prescaler_division_factor,
    output logic                           source_stalled
);

    localparam logic [`SCP_STALL_W-1:0] STALL_LIMIT =
        `SCP_STALL_W'(`SCP_STALL_CYCLES);

    // Synchroniser state.
    logic [`SCP_SRC_COUNT-1:0]  sync_meta;
    logic [`SCP_SRC_COUNT-1:0]  sync_level;
    logic [`SCP_SRC_COUNT-1:0]  next_sync_meta;
    logic [`SCP_SRC_COUNT-1:0]  next_sync_level;

    // Configuration tracking.
    logic [`SCP_SEL_W-1:0]      sel_prev;
    logic                       bypass_prev;
    logic [`SCP_FIELD_W-1:0]    field_prev;
    logic                       osc_sel_prev;
    logic                       cfg_restart;
    logic                       next_cfg_restart;

    // Output and status state.
    logic                       next_system_clock;
    scp_pkg::scp_mode_t         next_active_mode;
    logic [`SCP_FACTOR_W-1:0]   next_factor;
    logic                       next_source_stalled;
    logic [`SCP_STALL_W-1:0]    quiet_cnt;
    logic [`SCP_STALL_W-1:0]    next_quiet_cnt;
    logic                       watch_prev;
    logic                       next_watch_prev;

    // Combinational helpers.
    logic                       osc_level;
    logic                       div_clk;
    logic                       watch_level;
    scp_pkg::scp_mode_t         mode_now;

    // Every clock input arrives from outside this domain.
    always_comb begin
        next_sync_meta  = {wakeup_clock_input,
                           pll_clock_input,
                           internal_clock_input,
                           crystal_input,
                           direct_clock_input};
        next_sync_level = sync_meta;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_meta  <= `SCP_SYNC_RST;
            sync_level <= `SCP_SYNC_RST;
        end else if (ce) begin
            sync_meta  <= next_sync_meta;
            sync_level <= next_sync_level;
        end
    end

    // Decode the operating mode from select and bypass.
    always_comb begin
        if (clock_source_select == `SCP_SEL_DIRECT) begin
            mode_now = scp_pkg::SCP_MODE_DIRECT;
        end else if (clock_source_select == `SCP_SEL_PLL_PRESC) begin
            if (vco_bypass) begin
                mode_now = scp_pkg::SCP_MODE_PRESCALER;
            end else begin
                mode_now = scp_pkg::SCP_MODE_PLL;
            end
        end else if (clock_source_select == `SCP_SEL_WAKEUP) begin
            mode_now = scp_pkg::SCP_MODE_WAKEUP;
        end else begin
            mode_now = scp_pkg::SCP_MODE_RESERVED;
        end
    end

    // The prescaler takes either the crystal or the internal source.
    always_comb begin
        if (osc_internal_select) begin
            osc_level = sync_level[`SCP_IDX_INTERNAL];
        end else begin
            osc_level = sync_level[`SCP_IDX_CRYSTAL];
        end
    end

    // Any change of configuration restarts the divide so that the
    // first output period after a change comes from the new setting;
    // for factors above two its high phase is one input period short.
    always_comb begin
        next_cfg_restart = (clock_source_select != sel_prev)
                        || (vco_bypass != bypass_prev)
                        || (prescaler_divide_field != field_prev)
                        || (osc_internal_select != osc_sel_prev);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_prev     <= `SCP_SEL_RST;
            bypass_prev  <= 1'b0;
            field_prev   <= `SCP_FIELD_RST;
            osc_sel_prev <= 1'b0;
            cfg_restart  <= 1'b1;
        end else if (ce) begin
            sel_prev     <= clock_source_select;
            bypass_prev  <= vco_bypass;
            field_prev   <= prescaler_divide_field;
            osc_sel_prev <= osc_internal_select;
            cfg_restart  <= next_cfg_restart;
        end
    end

    scp_prescaler u_prescaler (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .ce           (ce),
        .restart      (cfg_restart),
        .divide_field (prescaler_divide_field),
        .osc_level    (osc_level),
        .div_clk      (div_clk)
    );

    // The source watched for activity is the one feeding the output.
    always_comb begin
        case (mode_now)
            scp_pkg::SCP_MODE_DIRECT:
                watch_level = sync_level[`SCP_IDX_DIRECT];
            scp_pkg::SCP_MODE_PRESCALER:
                watch_level = osc_level;
            scp_pkg::SCP_MODE_PLL:
                watch_level = sync_level[`SCP_IDX_PLL];
            scp_pkg::SCP_MODE_WAKEUP:
                watch_level = sync_level[`SCP_IDX_WAKEUP];
            default:
                watch_level = 1'b0;
        endcase
    end

    // Output mux. Reserved select holds the clock low rather than
    // guessing a source. The direct path is sampled at the system
    // rate, so its high and low times follow the input to within one
    // clock period.
    always_comb begin
        next_active_mode = mode_now;
        next_factor      = scp_pkg::scp_factor(prescaler_divide_field);
        case (mode_now)
            scp_pkg::SCP_MODE_DIRECT: begin
                next_system_clock = sync_level[`SCP_IDX_DIRECT];
            end
            scp_pkg::SCP_MODE_PRESCALER: begin
                next_system_clock = div_clk;
            end
            scp_pkg::SCP_MODE_PLL: begin
                next_system_clock = sync_level[`SCP_IDX_PLL];
            end
            scp_pkg::SCP_MODE_WAKEUP: begin
                next_system_clock = sync_level[`SCP_IDX_WAKEUP];
            end
            default: begin
                next_system_clock = 1'b0;
            end
        endcase
    end

    // A selected source that has not toggled for the stall time is
    // flagged; the flag drops on its next toggle. The limit sits above
    // the slowest wakeup period so a slow but live clock is not flagged.
    always_comb begin
        next_watch_prev     = watch_level;
        next_quiet_cnt      = quiet_cnt;
        next_source_stalled = source_stalled;
        if (cfg_restart || (watch_level != watch_prev)) begin
            next_quiet_cnt      = `SCP_STALL_RST;
            next_source_stalled = 1'b0;
        end else if (quiet_cnt >= STALL_LIMIT) begin
            next_source_stalled = 1'b1;
        end else begin
            next_quiet_cnt      = quiet_cnt + `SCP_STALL_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            system_clock              <= 1'b0;
            active_mode               <= scp_pkg::SCP_MODE_WAKEUP;
            prescaler_division_factor <= `SCP_FACTOR_RST;
            source_stalled            <= 1'b0;
            quiet_cnt                 <= `SCP_STALL_RST;
            watch_prev                <= 1'b0;
        end else if (ce) begin
            system_clock              <= next_system_clock;
            active_mode               <= next_active_mode;
            prescaler_division_factor <= next_factor;
            source_stalled            <= next_source_stalled;
            quiet_cnt                 <= next_quiet_cnt;
            watch_prev                <= next_watch_prev;
        end
    end

endmodule

// file: tb/scp_csp_asserts.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_csp_asserts (
    // Clock and reset
    input wire logic                     clk_sys,
    input wire logic                     nrst,
    input wire logic                     ce,
    // Configuration
    input wire logic [`SCP_SEL_W-1:0]    clock_source_select,
    input wire logic                     vco_bypass,
    input wire logic [`SCP_FIELD_W-1:0]  prescaler_divide_field,
    input wire logic                     osc_internal_select,
    // Clock sources
    input wire logic                     direct_clock_input,
    input wire logic                     crystal_input,
    input wire logic                     internal_clock_input,
    input wire logic                     pll_clock_input,
    input wire logic                     wakeup_clock_input,
    // Outputs
    input wire logic                     system_clock,
    input wire scp_pkg::scp_mode_t       active_mode,
    input wire logic [`SCP_FACTOR_W-1:0] prescaler_division_factor,
    input wire logic                     source_stalled
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Edges since the last config change or freeze; hides pipeline refill.
    logic [3:0]  calm;
    logic [3:0]  next_calm;
    logic [13:0] cfg_q;
    wire  [13:0] cfg = {clock_source_select, vco_bypass,
                        prescaler_divide_field, osc_internal_select};
    wire         src = osc_internal_select ? internal_clock_input
                                           : crystal_input;
    wire         presc = clock_source_select == 2'h2 && vco_bypass
                         && calm == 4'hf;

    always_comb begin
        next_calm = (calm == 4'hf) ? calm : calm + 4'h1;
        if (!ce || cfg != cfg_q) begin
            next_calm = 4'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            calm  <= 4'h0;
            cfg_q <= 14'h0000;
        end else begin
            calm  <= next_calm;
            cfg_q <= cfg;
        end
    end

    function automatic scp_pkg::scp_mode_t mode_of(input logic [1:0] s,
                                                   input logic v);
        case (s)
            2'h0: mode_of = scp_pkg::SCP_MODE_WAKEUP;
            2'h1: mode_of = scp_pkg::SCP_MODE_RESERVED;
            2'h2: mode_of = v ? scp_pkg::SCP_MODE_PRESCALER
                              : scp_pkg::SCP_MODE_PLL;
            default: mode_of = scp_pkg::SCP_MODE_DIRECT;
        endcase
    endfunction

    property p_direct;
        calm >= 4'h8 && clock_source_select == 2'h3
        |-> system_clock == $past(direct_clock_input, 3);
    endproperty
    property p_pll;
        calm >= 4'h8 && clock_source_select == 2'h2 && !vco_bypass
        |-> system_clock == $past(pll_clock_input, 3);
    endproperty
    property p_wakeup;
        calm >= 4'h8 && clock_source_select == 2'h0
        |-> system_clock == $past(wakeup_clock_input, 3);
    endproperty
    property p_reserved;
        calm >= 4'h4 && clock_source_select == 2'h1 |-> !system_clock;
    endproperty
    property p_unity;
        presc && prescaler_divide_field == 10'h000
        |-> system_clock == $past(src, 4);
    endproperty
    property p_rise;
        presc && $rose(system_clock) |-> $past(src, 4) && !$past(src, 5);
    endproperty
    property p_factor;
        ce |=> prescaler_division_factor
               == {1'b0, $past(prescaler_divide_field)} + 11'h001;
    endproperty
    property p_mode;
        ce |=> active_mode == mode_of($past(clock_source_select),
                                      $past(vco_bypass));
    endproperty
    // A flagged source is silent, so the clock it feeds cannot move.
    property p_stall;
        calm == 4'hf && source_stalled |-> $stable(system_clock);
    endproperty

    a_direct: assert property (p_direct)
        else $error("direct clock not passed through");
    a_pll: assert property (p_pll)
        else $error("pll clock not passed through");
    a_wakeup: assert property (p_wakeup)
        else $error("wakeup clock not passed through");
    a_reserved: assert property (p_reserved)
        else $error("reserved select drives a clock");
    a_unity: assert property (p_unity)
        else $error("factor one output differs from source");
    a_rise: assert property (p_rise)
        else $error("divided clock rose off a source rise");
    a_factor: assert property (p_factor)
        else $error("division factor is not field plus one");
    a_mode: assert property (p_mode)
        else $error("active mode does not match select");
    a_stall: assert property (p_stall)
        else $error("clock moved while its source is flagged silent");

    c_max: cover property (presc && prescaler_divide_field == 10'h3ff
                           && $rose(system_clock));
    c_direct: cover property (p_direct);
    c_reserved: cover property (calm >= 4'h4 && clock_source_select == 2'h1);
    c_stall: cover property ($rose(source_stalled));
endmodule

bind scp_clock_source_prescaler scp_csp_asserts u_asserts (
    .clk_sys, .nrst, .ce, .clock_source_select, .vco_bypass,
    .prescaler_divide_field, .osc_internal_select, .direct_clock_input,
    .crystal_input, .internal_clock_input, .pll_clock_input,
    .wakeup_clock_input, .system_clock, .active_mode,
    .prescaler_division_factor, .source_stalled
);

// file: tb/scp_clock_source_prescaler_tb.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_clock_source_prescaler_tb;
    logic               clk_sys = 1'b0;
    logic               nrst = 1'b0;
    logic               ce = 1'b1;
    logic [1:0]         sel = 2'h0;
    logic               vco = 1'b0;
    logic [9:0]         field = 10'h000;
    logic               osc = 1'b0;
    logic [5:0]         tick = 6'h00;
    logic               wake_run = 1'b1;
    logic               sys;
    scp_pkg::scp_mode_t mode;
    logic [10:0]        factor;
    logic               stalled;
    int                 failures = 0;
    int                 comparisons = 0;
    int                 cyc = 0;

    always #4 clk_sys = ~clk_sys;

    // Each source has its own period so a wrong route shows as a wrong rate.
    always @(posedge clk_sys) begin
        tick <= tick + 6'h01;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            end_of_test();
        end
    end

    scp_clock_source_prescaler u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .clock_source_select(sel), .vco_bypass(vco),
        .prescaler_divide_field(field), .osc_internal_select(osc),
        .direct_clock_input(tick[2]), .crystal_input(tick[1]),
        .internal_clock_input(tick[3]), .pll_clock_input(tick[4]),
        .wakeup_clock_input(tick[5] & wake_run), .system_clock(sys),
        .active_mode(mode), .prescaler_division_factor(factor),
        .source_stalled(stalled)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic set_cfg(input logic [1:0] s, input logic v,
                           input logic [9:0] f, input logic o);
        @(posedge clk_sys);
        sel <= s;
        vco <= v;
        field <= f;
        osc <= o;
        repeat (16) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (sys !== lvl && n < 20000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic mode_case(input logic [1:0] s, input logic v,
                             input scp_pkg::scp_mode_t em, input int er);
        int   r;
        logic p;
        set_cfg(s, v, 10'h000, 1'b0);
        check({29'h0, mode}, {29'h0, em});
        r = 0;
        p = sys;
        repeat (128) begin
            @(posedge clk_sys);
            #1;
            if (sys === 1'b1 && p === 1'b0) r++;
            p = sys;
        end
        check(r, er);
    endtask

    // Source period is given in clk_sys cycles.
    task automatic div_case(input logic [9:0] f, input logic o,
                            input int per_in);
        int hi;
        int lo;
        int k;
        int eh;
        k = f + 1;
        // Factor one keeps the source's own half-and-half duty cycle.
        eh = (k == 1) ? per_in / 2 : per_in * ((k + 1) / 2);
        set_cfg(2'h2, 1'b1, f, o);
        check(factor, {1'b0, f} + 11'h001);
        wait_lvl(1'b0, lo);
        wait_lvl(1'b1, lo);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, lo);
        check(hi + lo, per_in * k);
        check(hi, eh);
    endtask

    task automatic t_freeze;
        logic p;
        @(posedge clk_sys);
        ce <= 1'b0;
        field <= 10'h155;
        #1;
        p = sys;
        repeat (40) @(posedge clk_sys);
        #1;
        check(sys, p);
        check(factor, 11'h400);
        @(posedge clk_sys);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check(factor, 11'h156);
    endtask

    // The stop falls at an unknown phase of the wakeup source, so the
    // flag is looked at well before and well after its nominal time.
    task automatic t_stall;
        set_cfg(2'h0, 1'b0, 10'h000, 1'b0);
        @(posedge clk_sys);
        wake_run <= 1'b0;
        repeat (2400) @(posedge clk_sys);
        #1;
        check(stalled, 1'b0);
        repeat (200) @(posedge clk_sys);
        #1;
        check(stalled, 1'b1);
        check(sys, 1'b0);
        @(posedge clk_sys);
        wake_run <= 1'b1;
        repeat (80) @(posedge clk_sys);
        #1;
        check(stalled, 1'b0);
    endtask

    initial begin
        repeat (15) @(posedge clk_sys);
        #1;
        check(sys, 1'b0);
        check({29'h0, mode}, {29'h0, scp_pkg::SCP_MODE_WAKEUP});
        check(factor, 11'h001);
        check(stalled, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b1;
        mode_case(2'h3, 1'b0, scp_pkg::SCP_MODE_DIRECT, 16);
        mode_case(2'h2, 1'b0, scp_pkg::SCP_MODE_PLL, 4);
        mode_case(2'h0, 1'b0, scp_pkg::SCP_MODE_WAKEUP, 2);
        mode_case(2'h1, 1'b0, scp_pkg::SCP_MODE_RESERVED, 0);
        mode_case(2'h2, 1'b1, scp_pkg::SCP_MODE_PRESCALER, 32);
        div_case(10'h000, 1'b0, 4);
        div_case(10'h000, 1'b1, 16);
        div_case(10'h001, 1'b0, 4);
        div_case(10'h002, 1'b0, 4);
        div_case(10'h3ff, 1'b0, 4);
        t_freeze();
        t_stall();
        end_of_test();
    end
endmodule
